// ---- hw/fifo_flag_offset_config.sv ----
// almost-empty / almost-full flag controller with strap-selected offsets and timing
//
// Functional notes
// - the block holds an empty offset and a full offset and offers eight preset pairs chosen during master reset.
// - load select high during master reset enables serial loading of the offsets.
// - load select low during master reset enables parallel loading of the offsets.
// - master reset also loads the preset pair picked by load select and the two default-select inputs.
// - both offsets can be read back on the parallel data output in either loading method.
// - there is no serial readback of the offsets.
// - offsets may be loaded and reloaded at any time from the second clock after master reset is released.
// - timing select high during master reset gives synchronous flags, low gives asynchronous flags.
// - in synchronous timing the almost-full flag changes only on write-clock edges.
// - in synchronous timing the almost-empty flag changes only on read-clock edges.
// - in asynchronous timing almost-full falls on a write edge and rises on a read edge.
// - in asynchronous timing almost-empty falls on a read edge and rises on a write edge.
`timescale 1ns/1ps
module fifo_flag_offset_config
(
    // clock and reset
    input  wire logic                                   clock,
    input  wire logic                                   rst,
    // straps, sampled while master reset is low
    input  wire logic                                   master_reset_n,
    input  wire logic                                   offset_load_select_n,
    input  wire logic                                   default_offset_select_0,
    input  wire logic                                   default_offset_select_1,
    input  wire logic                                   flag_timing_select,
    // fifo port edges, one-cycle pulses
    input  wire logic                                   write_edge,
    input  wire logic                                   write_enable,
    input  wire logic                                   read_edge,
    input  wire logic                                   read_enable,
    // offset programming
    input  wire logic                                   parallel_write,
    input  wire logic                                   parallel_sel_full,
    input  wire logic [fifo_flag_pkg::OFFSET_W-1:0]     parallel_data,
    input  wire logic                                   serial_shift,
    input  wire logic                                   serial_bit,
    input  wire logic                                   offset_read,
    input  wire logic                                   offset_read_sel_full,
    // flags and readback
    output logic                                        almost_empty_flag_n,
    output logic                                        almost_full_flag_n,
    output logic [fifo_flag_pkg::DATA_W-1:0]            data_output_bus,
    output logic                                        serial_load_mode,
    output logic                                        async_flag_timing
);

    offset_prog_if prog ();

    fifo_flag_pkg::ctl_state_e              state_r;
    fifo_flag_pkg::ctl_state_e              state_nxt;
    logic                                   serial_r;
    logic                                   serial_nxt;
    logic                                   async_r;
    logic                                   async_nxt;
    logic [fifo_flag_pkg::COUNT_W-1:0]      count_r;
    logic [fifo_flag_pkg::COUNT_W-1:0]      count_nxt;
    logic                                   ae_r;
    logic                                   ae_nxt;
    logic                                   af_r;
    logic                                   af_nxt;
    logic [fifo_flag_pkg::DATA_W-1:0]       dout_r;
    logic [fifo_flag_pkg::DATA_W-1:0]       dout_nxt;
    logic                                   push;
    logic                                   pop;
    logic                                   near_empty;
    logic                                   near_full;
    logic                                   running;

    // ------------------------------------------------------------
    // offset store hookup
    // ------------------------------------------------------------
    assign running                = (state_r == fifo_flag_pkg::ST_RUN) && master_reset_n;
    assign prog.load_default      = !master_reset_n;
    assign prog.default_idx       = {offset_load_select_n, default_offset_select_1, default_offset_select_0};
    assign prog.serial_mode       = serial_r;
    assign prog.run               = running;
    assign prog.parallel_write    = parallel_write;
    assign prog.parallel_sel_full = parallel_sel_full;
    assign prog.parallel_data     = parallel_data;
    assign prog.serial_shift      = serial_shift;
    assign prog.serial_bit        = serial_bit;

    offset_regs u_offset_regs
    (
        .clock (clock),
        .rst   (rst),
        .prog  (prog)
    );

    // ------------------------------------------------------------
    // occupancy and thresholds
    // ------------------------------------------------------------
    assign push = write_edge && write_enable && (count_r != fifo_flag_pkg::DEPTH);
    assign pop  = read_edge && read_enable && (count_r != fifo_flag_pkg::COUNT_ZERO);

    // thresholds look at the post-edge count, so the flag matches the word just moved
    assign near_empty = (count_nxt <= {1'b0, prog.empty_off});
    assign near_full  = (count_nxt >= (fifo_flag_pkg::DEPTH - {1'b0, prog.full_off}));

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt  = state_r;
        serial_nxt = serial_r;
        async_nxt  = async_r;
        count_nxt  = count_r;
        ae_nxt     = ae_r;
        af_nxt     = af_r;
        dout_nxt   = dout_r;
        if (push && !pop)
            count_nxt = count_r + fifo_flag_pkg::COUNT_ONE;
        else if (pop && !push)
            count_nxt = count_r - fifo_flag_pkg::COUNT_ONE;
        if (!master_reset_n)
        begin
            state_nxt  = fifo_flag_pkg::ST_RESET;
            serial_nxt = offset_load_select_n;
            async_nxt  = !flag_timing_select;
            count_nxt  = fifo_flag_pkg::COUNT_ZERO;
            ae_nxt     = 1'b0;
            af_nxt     = 1'b1;
        end
        else
        begin
            case (state_r)
                fifo_flag_pkg::ST_RESET:
                begin
                    state_nxt = fifo_flag_pkg::ST_RUN;
                    count_nxt = fifo_flag_pkg::COUNT_ZERO;
                end
                fifo_flag_pkg::ST_RUN:
                begin
                    if (!async_r)
                    begin
                        if (write_edge)
                            af_nxt = !near_full;
                        if (read_edge)
                            ae_nxt = !near_empty;
                    end
                    else
                    begin
                        if (write_edge && near_full)
                            af_nxt = 1'b0;
                        else if (read_edge && !near_full)
                            af_nxt = 1'b1;
                        if (read_edge && near_empty)
                            ae_nxt = 1'b0;
                        else if (write_edge && !near_empty)
                            ae_nxt = 1'b1;
                    end
                    // readback is parallel only, no serial path out
                    if (offset_read)
                    begin
                        if (offset_read_sel_full)
                            dout_nxt = {{(fifo_flag_pkg::DATA_W-fifo_flag_pkg::OFFSET_W){1'b0}},
                                        prog.full_off};
                        else
                            dout_nxt = {{(fifo_flag_pkg::DATA_W-fifo_flag_pkg::OFFSET_W){1'b0}},
                                        prog.empty_off};
                    end
                end
                default:
                begin
                    state_nxt = fifo_flag_pkg::ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r  <= fifo_flag_pkg::ST_RESET;
            serial_r <= 1'b0;
            async_r  <= 1'b0;
            count_r  <= fifo_flag_pkg::COUNT_ZERO;
            ae_r     <= 1'b0;
            af_r     <= 1'b1;
            dout_r   <= '0;
        end
        else
        begin
            state_r  <= state_nxt;
            serial_r <= serial_nxt;
            async_r  <= async_nxt;
            count_r  <= count_nxt;
            ae_r     <= ae_nxt;
            af_r     <= af_nxt;
            dout_r   <= dout_nxt;
        end
    end

    assign almost_empty_flag_n = ae_r;
    assign almost_full_flag_n  = af_r;
    assign data_output_bus     = dout_r;
    assign serial_load_mode    = serial_r;
    assign async_flag_timing   = async_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    strap_load_mode_a: assert property (@(posedge clock) disable iff (rst)
        !master_reset_n |=> (serial_load_mode == $past(offset_load_select_n)))
        else $error("load method not taken from strap");

    strap_timing_a: assert property (@(posedge clock) disable iff (rst)
        !master_reset_n |=> (async_flag_timing == !$past(flag_timing_select)))
        else $error("flag timing not taken from strap");

    sync_full_hold_a: assert property (@(posedge clock) disable iff (rst)
        (running && !async_r && !write_edge) |=> $stable(almost_full_flag_n))
        else $error("sync almost-full moved without a write edge");

    sync_empty_hold_a: assert property (@(posedge clock) disable iff (rst)
        (running && !async_r && !read_edge) |=> $stable(almost_empty_flag_n))
        else $error("sync almost-empty moved without a read edge");

    async_full_fall_a: assert property (@(posedge clock) disable iff (rst)
        (running && async_r && !write_edge) |=> !$fell(almost_full_flag_n))
        else $error("async almost-full fell without a write edge");

    async_full_rise_a: assert property (@(posedge clock) disable iff (rst)
        (running && async_r && !read_edge) |=> !$rose(almost_full_flag_n))
        else $error("async almost-full rose without a read edge");

    async_empty_fall_a: assert property (@(posedge clock) disable iff (rst)
        (running && async_r && !read_edge) |=> !$fell(almost_empty_flag_n))
        else $error("async almost-empty fell without a read edge");

    async_empty_rise_a: assert property (@(posedge clock) disable iff (rst)
        (running && async_r && !write_edge) |=> !$rose(almost_empty_flag_n))
        else $error("async almost-empty rose without a write edge");

    readback_empty_a: assert property (@(posedge clock) disable iff (rst)
        (running && offset_read && !offset_read_sel_full)
        |=> (data_output_bus[fifo_flag_pkg::OFFSET_W-1:0] == $past(prog.empty_off)))
        else $error("empty offset readback wrong");

    readback_full_a: assert property (@(posedge clock) disable iff (rst)
        (running && offset_read && offset_read_sel_full)
        |=> (data_output_bus[fifo_flag_pkg::OFFSET_W-1:0] == $past(prog.full_off)))
        else $error("full offset readback wrong");

endmodule

// ---- pkg/fifo_flag_pkg.sv ----
// constants, types and helpers shared by the flag offset configuration logic
package fifo_flag_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int OFFSET_W   = 9;
    localparam int COUNT_W    = 10;
    localparam int DATA_W     = 72;
    localparam int SEL_W      = 3;
    localparam int NUM_PRESET = 8;
    localparam logic [COUNT_W-1:0] DEPTH      = 10'h200;
    localparam logic [COUNT_W-1:0] COUNT_ZERO = 10'h000;
    localparam logic [COUNT_W-1:0] COUNT_ONE  = 10'h001;

    // ------------------------------------------------------------
    // preset offset pairs, indexed by {load select, select 1, select 0}
    // ------------------------------------------------------------
    localparam logic [OFFSET_W-1:0] PRESET_0 = 9'h07F;
    localparam logic [OFFSET_W-1:0] PRESET_1 = 9'h007;
    localparam logic [OFFSET_W-1:0] PRESET_2 = 9'h00F;
    localparam logic [OFFSET_W-1:0] PRESET_3 = 9'h01F;
    localparam logic [OFFSET_W-1:0] PRESET_4 = 9'h03F;
    localparam logic [OFFSET_W-1:0] PRESET_5 = 9'h0FF;
    localparam logic [OFFSET_W-1:0] PRESET_6 = 9'h1FF;
    localparam logic [OFFSET_W-1:0] PRESET_7 = 9'h003;

    // control sequencing
    typedef enum logic [1:0]
    {
        ST_RESET = 2'b01,
        ST_RUN   = 2'b10
    } ctl_state_e;

    function automatic logic [OFFSET_W-1:0] preset_offset(input logic [SEL_W-1:0] idx);
        logic [OFFSET_W-1:0] v;
        v = PRESET_0;
        case (idx)
            3'h0:    v = PRESET_0;
            3'h1:    v = PRESET_1;
            3'h2:    v = PRESET_2;
            3'h3:    v = PRESET_3;
            3'h4:    v = PRESET_4;
            3'h5:    v = PRESET_5;
            3'h6:    v = PRESET_6;
            3'h7:    v = PRESET_7;
            default: v = PRESET_0;
        endcase
        return v;
    endfunction

endpackage

// ---- pkg/offset_prog_if.sv ----
// carrier between the flag controller and its offset register store
`timescale 1ns/1ps
interface offset_prog_if;
    logic                                   load_default;
    logic [fifo_flag_pkg::SEL_W-1:0]        default_idx;
    logic                                   serial_mode;
    logic                                   run;
    logic                                   parallel_write;
    logic                                   parallel_sel_full;
    logic [fifo_flag_pkg::OFFSET_W-1:0]     parallel_data;
    logic                                   serial_shift;
    logic                                   serial_bit;
    logic [fifo_flag_pkg::OFFSET_W-1:0]     empty_off;
    logic [fifo_flag_pkg::OFFSET_W-1:0]     full_off;

    modport ctl
    (
        output load_default, default_idx, serial_mode, run,
        output parallel_write, parallel_sel_full, parallel_data, serial_shift, serial_bit,
        input  empty_off, full_off
    );
    modport regs
    (
        input  load_default, default_idx, serial_mode, run,
        input  parallel_write, parallel_sel_full, parallel_data, serial_shift, serial_bit,
        output empty_off, full_off
    );
endinterface

// ---- hw/offset_regs.sv ----
// almost-empty and almost-full offset registers with preset, serial and parallel load
`timescale 1ns/1ps
module offset_regs
(
    // clock and reset
    input wire logic         clock,
    input wire logic         rst,
    // controller side
    offset_prog_if.regs      prog
);

    logic [fifo_flag_pkg::OFFSET_W-1:0] empty_r;
    logic [fifo_flag_pkg::OFFSET_W-1:0] empty_nxt;
    logic [fifo_flag_pkg::OFFSET_W-1:0] full_r;
    logic [fifo_flag_pkg::OFFSET_W-1:0] full_nxt;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb
    begin
        empty_nxt = empty_r;
        full_nxt  = full_r;
        if (prog.load_default)
        begin
            empty_nxt = fifo_flag_pkg::preset_offset(prog.default_idx);
            full_nxt  = fifo_flag_pkg::preset_offset(prog.default_idx);
        end
        else if (prog.run && prog.serial_mode && prog.serial_shift)
        begin
            // one chain: empty offset first, msb first, spilling into the full offset
            {empty_nxt, full_nxt} = {empty_r[fifo_flag_pkg::OFFSET_W-2:0], full_r, prog.serial_bit};
        end
        else if (prog.run && !prog.serial_mode && prog.parallel_write)
        begin
            if (prog.parallel_sel_full)
                full_nxt = prog.parallel_data;
            else
                empty_nxt = prog.parallel_data;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            empty_r <= fifo_flag_pkg::PRESET_0;
            full_r  <= fifo_flag_pkg::PRESET_0;
        end
        else
        begin
            empty_r <= empty_nxt;
            full_r  <= full_nxt;
        end
    end

    assign prog.empty_off = empty_r;
    assign prog.full_off  = full_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    preset_load_a: assert property (@(posedge clock) disable iff (rst)
        prog.load_default |=> (empty_r == fifo_flag_pkg::preset_offset($past(prog.default_idx)))
                              && (full_r == fifo_flag_pkg::preset_offset($past(prog.default_idx))))
        else $error("preset offset pair not loaded");

    serial_ignores_par_a: assert property (@(posedge clock) disable iff (rst)
        (prog.serial_mode && !prog.serial_shift && !prog.load_default) |=> $stable(full_r) && $stable(empty_r))
        else $error("offset changed in serial mode without a shift");

    par_ignores_ser_a: assert property (@(posedge clock) disable iff (rst)
        (!prog.serial_mode && !prog.parallel_write && !prog.load_default) |=> $stable(full_r) && $stable(empty_r))
        else $error("offset changed in parallel mode without a write");

endmodule

// ---- bench/fifo_host_model.sv ----
// far-side host model making write and read clock edge pulses
`timescale 1ns/1ps
module fifo_host_model
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // edge spacing in cycles, zero stalls that side
    input  wire logic [3:0] wdiv,
    input  wire logic [3:0] rdiv,
    input  wire logic       wr_on,
    input  wire logic       rd_on,
    // fifo port edges
    output logic            write_edge,
    output logic            write_enable,
    output logic            read_edge,
    output logic            read_enable
);
    logic [3:0] wc;
    logic [3:0] rc;

    initial
    begin
        {wc, rc} = 8'h00;
        {write_edge, write_enable, read_edge, read_enable} = 4'h0;
    end

    // both clocks are modelled as pulses so they may coincide
    always @(negedge clock)
    begin
        if (rst)
        begin
            {wc, rc} <= 8'h00;
            {write_edge, read_edge} <= 2'b00;
        end
        else
        begin
            wc <= (wc + 4'h1 >= wdiv) ? 4'h0 : wc + 4'h1;
            rc <= (rc + 4'h1 >= rdiv) ? 4'h0 : rc + 4'h1;
            write_edge <= (wdiv != 4'h0) && (wc + 4'h1 >= wdiv);
            read_edge <= (rdiv != 4'h0) && (rc + 4'h1 >= rdiv);
        end
        write_enable <= wr_on;
        read_enable <= rd_on;
    end
endmodule

// ---- bench/fifo_flag_offset_config_tb_top.sv ----
// self-checking bench for the flag offset configuration block
`timescale 1ns/1ps
module fifo_flag_offset_config_tb_top;
    // ----
    // signals and model state
    // ----
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        master_reset_n = 1'b0;
    logic        offset_load_select_n = 1'b0;
    logic        default_offset_select_0 = 1'b0;
    logic        default_offset_select_1 = 1'b0;
    logic        flag_timing_select = 1'b1;
    logic        parallel_write = 1'b0;
    logic        parallel_sel_full = 1'b0;
    logic [8:0]  parallel_data = 9'h000;
    logic        serial_shift = 1'b0;
    logic        serial_bit = 1'b0;
    logic        offset_read = 1'b0;
    logic        offset_read_sel_full = 1'b0;
    logic [3:0]  wdiv = 4'h0;
    logic [3:0]  rdiv = 4'h0;
    logic        wr_on = 1'b0;
    logic        rd_on = 1'b0;
    logic        write_edge, write_enable, read_edge, read_enable;
    logic        almost_empty_flag_n, almost_full_flag_n, serial_load_mode, async_flag_timing;
    logic [71:0] data_output_bus;
    logic [17:0] ch;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cnt, eoff, foff, ae, af, dob, smode, amode, phase, nc, aec, afc;
    int          preset [8];
    bit          sq [$];

    always #10 clock = ~clock;

    fifo_flag_offset_config i_fifo_flag_offset_config (.clock, .rst, .master_reset_n, .offset_load_select_n,
        .default_offset_select_0, .default_offset_select_1, .flag_timing_select, .write_edge, .write_enable,
        .read_edge, .read_enable, .parallel_write, .parallel_sel_full, .parallel_data, .serial_shift,
        .serial_bit, .offset_read, .offset_read_sel_full, .almost_empty_flag_n, .almost_full_flag_n,
        .data_output_bus, .serial_load_mode, .async_flag_timing);
    fifo_host_model i_fifo_host_model (.clock, .rst, .wdiv, .rdiv, .wr_on, .rd_on, .write_edge,
        .write_enable, .read_edge, .read_enable);

    // ----
    // reference model
    // ----
    always @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ae = 0;
            af = 1;
            dob = 0;
            smode = 0;
            amode = 0;
            cnt = 0;
            phase = 0;
            eoff = 127;
            foff = 127;
        end
        else if (!master_reset_n)
        begin
            smode = offset_load_select_n;
            amode = !flag_timing_select;
            eoff = preset[{offset_load_select_n, default_offset_select_1, default_offset_select_0}];
            foff = eoff;
            cnt = 0;
            ae = 0;
            af = 1;
            phase = 0;
        end
        else if (phase == 0)
            phase = 1;
        else
        begin
            if (offset_read)
                dob = offset_read_sel_full ? foff : eoff;
            nc = cnt + int'(write_edge && write_enable && cnt < 512) - int'(read_edge && read_enable && cnt > 0);
            aec = int'(nc <= eoff);
            afc = int'(nc >= fifo_flag_pkg::DEPTH - foff);
            if (amode)
            begin
                if (write_edge && afc) af = 0;
                if (read_edge && !afc) af = 1;
                if (read_edge && aec) ae = 0;
                if (write_edge && !aec) ae = 1;
            end
            else
            begin
                if (write_edge) af = !afc;
                if (read_edge) ae = !aec;
            end
            cnt = nc;
            if (parallel_write && !smode && parallel_sel_full) foff = parallel_data;
            if (parallel_write && !smode && !parallel_sel_full) eoff = parallel_data;
            if (serial_shift && smode)
            begin
                // chain drops the empty msb, the new bit enters the full lsb
                ch = {8'(eoff), 9'(foff), serial_bit};
                eoff = int'(ch[17:9]);
                foff = int'(ch[8:0]);
            end
        end
    end

    always @(negedge clock)
        if (!rst)
        begin
            check("almost empty", almost_empty_flag_n, ae);
            check("almost full", almost_full_flag_n, af);
            check("serial mode", serial_load_mode, smode);
            check("async timing", async_flag_timing, amode);
        end

    // ----
    // tasks
    // ----
    task automatic check(input string nm, input logic [71:0] seen, input logic [71:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic mreset(input int idx, input bit sync);
        master_reset_n = 1'b0;
        {offset_load_select_n, default_offset_select_1, default_offset_select_0} = idx[2:0];
        flag_timing_select = sync;
        repeat (2) @(negedge clock);
        master_reset_n = 1'b1;
        repeat (2) @(negedge clock);
    endtask

    task automatic rd(input bit full);
        offset_read = 1'b1;
        offset_read_sel_full = full;
        @(negedge clock);
        offset_read = 1'b0;
        check("readback", data_output_bus, dob);
        @(negedge clock);
    endtask

    task automatic pw(input bit full, input logic [8:0] v);
        parallel_write = 1'b1;
        parallel_sel_full = full;
        parallel_data = v;
        @(negedge clock);
        parallel_write = 1'b0;
        @(negedge clock);
    endtask

    // shifts back to back, strobe held high across the whole queue
    task automatic shift(input int n);
        sq.delete();
        repeat (n) sq.push_back(1'($urandom));
        serial_shift = 1'b1;
        foreach (sq[i])
        begin
            serial_bit = sq[i];
            @(negedge clock);
        end
        serial_shift = 1'b0;
        @(negedge clock);
    endtask

    task automatic wait_cnt(input int t);
        for (int i = 0; i < 5000 && cnt != t; i++)
            @(negedge clock);
        if (cnt != t)
        begin
            bad_count++;
            $display("MISMATCH fill level expected %0d seen %0d", t, cnt);
            final_report();
        end
    endtask

    task automatic flow(input bit sync);
        mreset($urandom % 4, sync);
        pw(1'b0, 9'($urandom % 40));
        pw(1'b1, 9'($urandom % 40));
        {wr_on, rd_on} <= 2'b11;
        wdiv <= 4'(1 + $urandom % 2);
        wait_cnt(512);
        repeat (20) @(negedge clock);
        wdiv <= 4'h0;
        rdiv <= 4'(1 + $urandom % 3);
        wait_cnt(0);
        wdiv <= 4'(1 + $urandom % 3);
        repeat (400)
        begin
            @(negedge clock);
            rd_on <= 1'($urandom);
        end
        {wdiv, rdiv} <= 8'h00;
        @(negedge clock);
        $display("test flags sync=%0d done", sync);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----
    // main sequence
    // ----
    initial
    begin
        preset = '{fifo_flag_pkg::PRESET_0, fifo_flag_pkg::PRESET_1, fifo_flag_pkg::PRESET_2,
                   fifo_flag_pkg::PRESET_3, fifo_flag_pkg::PRESET_4, fifo_flag_pkg::PRESET_5,
                   fifo_flag_pkg::PRESET_6, fifo_flag_pkg::PRESET_7};
        void'($urandom(46));
        repeat (16) @(negedge clock);
        rst = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            mreset(i, 1'($urandom));
            rd(1'b0);
            rd(1'b1);
        end
        $display("test presets done");
        mreset(0, 1'b1);
        shift(3);
        pw(1'b1, 9'($urandom));
        pw(1'b0, 9'($urandom));
        rd(1'b0);
        rd(1'b1);
        $display("test parallel done");
        mreset(4 + $urandom % 4, 1'b1);
        pw(1'b1, 9'h155);
        shift(18);
        rd(1'b0);
        rd(1'b1);
        shift(5);
        rd(1'b0);
        rd(1'b1);
        $display("test serial done");
        flow(1'b1);
        flow(1'b0);
        final_report();
    end
endmodule
